/* hdl/earm_pkg.sv */
// constants and carrier types for the auxiliary register map
//
// Contract
// - decode auxiliary PCI group, memory or indirect I/O
// - target status holds capture from target abort
// - master status registers are read only
// - bus access diagnostics read only, writes ignored
// - station address loaded at init, software writable
// - four card event registers carry interrupt bits
// - Ethernet registers mapped read/write, both cycle kinds
// - PHY window: 32 PHYs of 32 registers each (1024 slots), management access each
// - pause timer write sends one pause frame
// - filter compares destination against perfect memory
// - destination hash indexes the hash bitmap
// - transmit program loaded by software, word at tx_pc fetched here
// - receive program loaded by software, word at rx_pc fetched here
// - FIFO port gives diagnostic access to data FIFO
// - reserved reads zero, unmapped writes ignored
// - write action fires on most significant byte
// - clear-on-read only when top byte read
package earm_pkg;
   localparam int ADDR_W = 16;
   localparam int NETH = 19;
   localparam int CEV_W = 4;
   localparam int PM_WORDS = 64;
   localparam int HM_WORDS = 32;
   localparam int PROG_WORDS = 2048;
   localparam int PAUSE_W = 16;
   localparam int NPERF = 16;
   localparam logic [15:0] OFS_TGT = 16'h0100;
   localparam logic [15:0] OFS_MST_A = 16'h0104;
   localparam logic [15:0] OFS_MST_B = 16'h0108;
   localparam logic [15:0] OFS_DMA_PTR = 16'h010C;
   localparam logic [15:0] OFS_BAC0 = 16'h0110;
   localparam logic [15:0] OFS_BAC3 = 16'h011C;
   localparam logic [15:0] OFS_SA_LO = 16'h0120;
   localparam logic [15:0] OFS_SA_HI = 16'h0124;
   localparam logic [15:0] OFS_CEV = 16'h0130;
   localparam logic [15:0] OFS_CMASK = 16'h0134;
   localparam logic [15:0] OFS_CPRES = 16'h0138;
   localparam logic [15:0] OFS_CFORCE = 16'h013C;
   localparam logic [15:0] OFS_PHY_LO = 16'h2000;
   localparam logic [15:0] OFS_PHY_HI = 16'h3FFF;
   localparam logic [15:0] OFS_PM_LO = 16'h6000;
   localparam logic [15:0] OFS_PM_HI = 16'h60FF;
   localparam logic [15:0] OFS_HM_LO = 16'h6100;
   localparam logic [15:0] OFS_HM_HI = 16'h617F;
   localparam logic [15:0] OFS_STAT_LO = 16'h7000;
   localparam logic [15:0] OFS_STAT_HI = 16'h7FFF;
   localparam logic [15:0] OFS_TXP_LO = 16'h8000;
   localparam logic [15:0] OFS_TXP_HI = 16'h9FFF;
   localparam logic [15:0] OFS_RXP_LO = 16'hA000;
   localparam logic [15:0] OFS_RXP_HI = 16'hBFFF;
   localparam logic [15:0] OFS_FIFO_LO = 16'hC000;
   localparam logic [15:0] OFS_FIFO_HI = 16'hDFFF;
   localparam logic [15:0] ETH_OFS [NETH] = '{
      16'h4000, 16'h4004, 16'h4008, 16'h5000, 16'h5004, 16'h5008,
      16'h500C, 16'h5010, 16'h5014, 16'h5018, 16'h501C, 16'h5020,
      16'h5024, 16'h5028, 16'h5034, 16'h5040, 16'h5060, 16'h5064,
      16'h5070};
   localparam int IX_TOTAL_TX = 14;
   localparam int IX_RX_BYTES = 15;
   localparam int IX_PAUSE = 16;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;
   localparam logic [1:0] TGT_PHY = 2'h0;
   localparam logic [1:0] TGT_STAT = 2'h1;
   localparam logic [1:0] TGT_FIFO = 2'h2;
   typedef enum logic {ST_IDLE = 1'b0, ST_WAIT = 1'b1} earm_state_e;
   typedef struct packed {
      logic valid;
      logic write;
      logic io;
      logic [ADDR_W-1:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } earm_req_s;
   typedef struct packed {
      logic valid;
      logic write;
      logic [1:0] tgt;
      logic [4:0] phy;
      logic [4:0] reg_no;
      logic [ADDR_W-1:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } earm_ext_s;
   typedef struct packed {
      logic [31:0] mst_a;
      logic [31:0] mst_b;
      logic [31:0] dma_ptr;
      logic [3:0][31:0] bac;
   } earm_diag_s;
endpackage

/* hdl/earm_regmap.sv */
// auxiliary register map: diagnostics, card events, Ethernet registers
`timescale 1ns/1ps
module earm_regmap import earm_pkg::*; (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire earm_req_s bus_req,
   output logic bus_ack_r,
   output logic [31:0] bus_rdata_r,
   output logic bus_busy_r,
   input wire logic tgt_abort,
   input wire logic [31:0] tgt_diag,
   input wire earm_diag_s diag,
   input wire logic sa_load,
   input wire logic [47:0] sa_load_addr,
   input wire logic [CEV_W-1:0] card_evt_set,
   input wire logic [CEV_W-1:0] card_present,
   output logic card_irq_r,
   output earm_ext_s ext_r,
   input wire logic ext_done,
   input wire logic [31:0] ext_rdata,
   output logic pause_go_r,
   output logic [PAUSE_W-1:0] pause_time_r,
   input wire logic tx_done_inc,
   input wire logic rx_byte_inc,
   output logic [NETH-1:0][31:0] eth_cfg_r,
   input wire logic da_valid,
   input wire logic [47:0] da,
   output logic perf_hit_r,
   output logic hash_hit_r,
   input wire logic [10:0] tx_pc,
   output logic [31:0] tx_insn_r,
   input wire logic [10:0] rx_pc,
   output logic [31:0] rx_insn_r
);
   // ****************************************
   // state and storage
   // ****************************************
   earm_state_e st_r, st_nxt;
   logic ack_nxt, busy_nxt, irq_nxt, go_nxt, umap;
   logic [31:0] rd_nxt, tdiag_r, tdiag_nxt, sa_lo_r, sa_lo_nxt;
   logic [15:0] sa_hi_r, sa_hi_nxt;
   logic [CEV_W-1:0] cev_r, cev_nxt, cmask_r, cmask_nxt;
   logic [PAUSE_W-1:0] ptime_nxt;
   logic [NETH-1:0][31:0] eth_nxt;
   earm_ext_s ext_nxt;
   logic [15:0] perf_mem [PM_WORDS];
   logic [15:0] hash_mem [HM_WORDS];
   logic [31:0] tx_prog [PROG_WORDS];
   logic [31:0] rx_prog [PROG_WORDS];
   logic pm_we, hm_we, txp_we, rxp_we;
   logic [NPERF-1:0] perf_hit;
   logic [8:0] hidx;
   logic [15:0] a;
   logic take, rd, wr;

   function automatic logic [31:0] f_merge(input logic [31:0] o,
      input logic [31:0] w, input logic [3:0] be);
      for (int i = 0; i < 4; i++) begin
         f_merge[i*8 +: 8] = be[i] ? w[i*8 +: 8] : o[i*8 +: 8];
      end
   endfunction

   function automatic logic in_rng(input logic [15:0] x,
      input logic [15:0] lo, input logic [15:0] hi);
      in_rng = (x >= lo) && (x <= hi);
   endfunction

   // word offset within the internal register space
   assign a = {bus_req.addr[15:2], 2'b00};
   assign take = bus_req.valid && (st_r == ST_IDLE);
   assign rd = take && !bus_req.write;
   assign wr = take && bus_req.write;

   // ****************************************
   // address filter
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < NPERF; g++) begin : g_perf
         assign perf_hit[g] = {perf_mem[g*4+2], perf_mem[g*4+1],
            perf_mem[g*4]} == da;
      end
   endgenerate
   // xor fold of the destination into a bitmap index
   assign hidx = da[8:0] ^ da[17:9] ^ da[26:18] ^ da[35:27] ^ da[44:36]
      ^ {6'h00, da[47:45]};

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      st_nxt = st_r;
      ack_nxt = 1'b0;
      rd_nxt = bus_rdata_r;
      ext_nxt = ext_r;
      tdiag_nxt = tgt_abort ? tgt_diag : tdiag_r;
      sa_lo_nxt = sa_lo_r;
      sa_hi_nxt = sa_hi_r;
      cev_nxt = cev_r;
      cmask_nxt = cmask_r;
      eth_nxt = eth_cfg_r;
      go_nxt = 1'b0;
      ptime_nxt = pause_time_r;
      pm_we = 1'b0;
      hm_we = 1'b0;
      txp_we = 1'b0;
      rxp_we = 1'b0;
      umap = 1'b0;
      if (sa_load) begin
         sa_lo_nxt = sa_load_addr[31:0];
         sa_hi_nxt = sa_load_addr[47:32];
      end
      if (st_r == ST_WAIT) begin
         if (ext_done) begin
            ext_nxt.valid = 1'b0;
            ack_nxt = 1'b1;
            rd_nxt = ext_r.write ? ZERO32 : ext_rdata;
            st_nxt = ST_IDLE;
         end
      end else if (take) begin
         if (in_rng(a, OFS_PHY_LO, OFS_PHY_HI)
            || in_rng(a, OFS_STAT_LO, OFS_STAT_HI)
            || in_rng(a, OFS_FIFO_LO, OFS_FIFO_HI)) begin
            ext_nxt.valid = 1'b1;
            ext_nxt.write = bus_req.write;
            ext_nxt.tgt = in_rng(a, OFS_PHY_LO, OFS_PHY_HI) ? TGT_PHY :
               in_rng(a, OFS_STAT_LO, OFS_STAT_HI) ? TGT_STAT : TGT_FIFO;
            ext_nxt.phy = a[11:7];
            ext_nxt.reg_no = a[6:2];
            ext_nxt.addr = a;
            ext_nxt.be = bus_req.be;
            ext_nxt.wdata = bus_req.wdata;
            st_nxt = ST_WAIT;
         end else begin
            ack_nxt = 1'b1;
            rd_nxt = ZERO32;
            if (a == OFS_TGT) begin
               rd_nxt = tdiag_r;
            end else if (a == OFS_MST_A) begin
               rd_nxt = diag.mst_a;
            end else if (a == OFS_MST_B) begin
               rd_nxt = diag.mst_b;
            end else if (a == OFS_DMA_PTR) begin
               rd_nxt = diag.dma_ptr;
            end else if (in_rng(a, OFS_BAC0, OFS_BAC3)) begin
               rd_nxt = diag.bac[a[3:2]];
            end else if (a == OFS_SA_LO) begin
               rd_nxt = sa_lo_r;
               if (wr) sa_lo_nxt = f_merge(sa_lo_r, bus_req.wdata,
                  bus_req.be);
            end else if (a == OFS_SA_HI) begin
               rd_nxt = {16'h0000, sa_hi_r};
               if (wr) sa_hi_nxt = 16'(f_merge({16'h0000, sa_hi_r},
                  bus_req.wdata, bus_req.be));
            end else if (a == OFS_CEV) begin
               rd_nxt = {{(32-CEV_W){1'b0}}, cev_r};
               if (wr) cev_nxt = cev_r & ~bus_req.wdata[CEV_W-1:0];
            end else if (a == OFS_CMASK) begin
               rd_nxt = {{(32-CEV_W){1'b0}}, cmask_r};
               if (wr) cmask_nxt = bus_req.wdata[CEV_W-1:0];
            end else if (a == OFS_CPRES) begin
               rd_nxt = {{(32-CEV_W){1'b0}}, card_present};
            end else if (a == OFS_CFORCE) begin
               if (wr) cev_nxt = cev_nxt | bus_req.wdata[CEV_W-1:0];
            end else if (in_rng(a, OFS_PM_LO, OFS_PM_HI)) begin
               rd_nxt = {16'h0000, perf_mem[a[7:2]]};
               pm_we = wr;
            end else if (in_rng(a, OFS_HM_LO, OFS_HM_HI)) begin
               rd_nxt = {16'h0000, hash_mem[a[6:2]]};
               hm_we = wr;
            end else if (in_rng(a, OFS_TXP_LO, OFS_TXP_HI)) begin
               rd_nxt = tx_prog[a[12:2]];
               txp_we = wr;
            end else if (in_rng(a, OFS_RXP_LO, OFS_RXP_HI)) begin
               rd_nxt = rx_prog[a[12:2]];
               rxp_we = wr;
            end else begin
               umap = 1'b1;
               for (int i = 0; i < NETH; i++) begin
                  if (a == ETH_OFS[i]) begin
                     umap = 1'b0;
                     rd_nxt = eth_cfg_r[i];
                     if (wr) eth_nxt[i] = f_merge(eth_cfg_r[i],
                        bus_req.wdata, bus_req.be);
                  end
               end
               if (wr && a == ETH_OFS[IX_PAUSE] && bus_req.be[3]) begin
                  go_nxt = 1'b1;
                  ptime_nxt = eth_nxt[IX_PAUSE][PAUSE_W-1:0];
               end
            end
         end
      end
      // clear on read of the top byte; a count in the same cycle wins
      if (rd && bus_req.be[3] && a == ETH_OFS[IX_TOTAL_TX]) begin
         eth_nxt[IX_TOTAL_TX] = ZERO32;
      end
      if (rd && bus_req.be[3] && a == ETH_OFS[IX_RX_BYTES]) begin
         eth_nxt[IX_RX_BYTES] = ZERO32;
      end
      if (tx_done_inc) begin
         eth_nxt[IX_TOTAL_TX] = eth_nxt[IX_TOTAL_TX] + 32'h0000_0001;
      end
      if (rx_byte_inc) begin
         eth_nxt[IX_RX_BYTES] = eth_nxt[IX_RX_BYTES] + 32'h0000_0001;
      end
      cev_nxt = cev_nxt | card_evt_set;
      busy_nxt = (st_nxt == ST_WAIT);
      irq_nxt = |(cev_r & cmask_r);
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= ST_IDLE;
         bus_ack_r <= 1'b0;
         bus_rdata_r <= ZERO32;
         bus_busy_r <= 1'b0;
         ext_r <= '0;
         tdiag_r <= ZERO32;
         sa_lo_r <= ZERO32;
         sa_hi_r <= 16'h0000;
         cev_r <= '0;
         cmask_r <= '0;
         card_irq_r <= 1'b0;
         eth_cfg_r <= '0;
         pause_go_r <= 1'b0;
         pause_time_r <= '0;
      end else begin
         st_r <= st_nxt;
         bus_ack_r <= ack_nxt;
         bus_rdata_r <= rd_nxt;
         bus_busy_r <= busy_nxt;
         ext_r <= ext_nxt;
         tdiag_r <= tdiag_nxt;
         sa_lo_r <= sa_lo_nxt;
         sa_hi_r <= sa_hi_nxt;
         cev_r <= cev_nxt;
         cmask_r <= cmask_nxt;
         card_irq_r <= irq_nxt;
         eth_cfg_r <= eth_nxt;
         pause_go_r <= go_nxt;
         pause_time_r <= ptime_nxt;
      end
   end

   // memories, filter results and program fetch
   always_ff @(posedge ref_clk) begin
      if (pm_we) perf_mem[a[7:2]] <= 16'(f_merge({16'h0000,
         perf_mem[a[7:2]]}, bus_req.wdata, bus_req.be));
      if (hm_we) hash_mem[a[6:2]] <= 16'(f_merge({16'h0000,
         hash_mem[a[6:2]]}, bus_req.wdata, bus_req.be));
      if (txp_we) tx_prog[a[12:2]] <= f_merge(tx_prog[a[12:2]],
         bus_req.wdata, bus_req.be);
      if (rxp_we) rx_prog[a[12:2]] <= f_merge(rx_prog[a[12:2]],
         bus_req.wdata, bus_req.be);
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         perf_hit_r <= 1'b0;
         hash_hit_r <= 1'b0;
         tx_insn_r <= ZERO32;
         rx_insn_r <= ZERO32;
      end else begin
         perf_hit_r <= da_valid && (|perf_hit);
         hash_hit_r <= da_valid && hash_mem[hidx[8:4]][hidx[3:0]];
         tx_insn_r <= tx_prog[tx_pc];
         rx_insn_r <= rx_prog[rx_pc];
      end
   end

   // ****************************************
   // checks
   // ****************************************
   property p_tgt_cap;
      @(posedge ref_clk) disable iff (!arst_n)
      tgt_abort |=> tdiag_r == $past(tgt_diag);
   endproperty
   a_tgt_cap: assert property (p_tgt_cap)
      else $error("target status not captured");
   property p_bac_ro;
      @(posedge ref_clk) disable iff (!arst_n)
      take && a == OFS_BAC0 |=> bus_ack_r
         && bus_rdata_r == $past(diag.bac[0]);
   endproperty
   a_bac_ro: assert property (p_bac_ro)
      else $error("diagnostic read wrong");
   property p_sa_load;
      @(posedge ref_clk) disable iff (!arst_n)
      sa_load && !wr |=> sa_lo_r == $past(sa_load_addr[31:0])
         && sa_hi_r == $past(sa_load_addr[47:32]);
   endproperty
   a_sa_load: assert property (p_sa_load)
      else $error("station address not loaded");
   property p_irq;
      @(posedge ref_clk) disable iff (!arst_n)
      |(cev_r & cmask_r) |=> card_irq_r;
   endproperty
   a_irq: assert property (p_irq)
      else $error("card interrupt missing");
   property p_phy;
      @(posedge ref_clk) disable iff (!arst_n)
      take && in_rng(a, OFS_PHY_LO, OFS_PHY_HI) |=> ext_r.valid
         && ext_r.tgt == TGT_PHY && ext_r.phy == $past(a[11:7]);
   endproperty
   a_phy: assert property (p_phy)
      else $error("management access not issued");
   property p_pause;
      @(posedge ref_clk) disable iff (!arst_n)
      wr && a == ETH_OFS[IX_PAUSE] && bus_req.be[3] |=> pause_go_r
         && pause_time_r == eth_cfg_r[IX_PAUSE][PAUSE_W-1:0] ##1 !pause_go_r;
   endproperty
   a_pause: assert property (p_pause)
      else $error("pause frame request wrong");
   property p_no_pause;
      @(posedge ref_clk) disable iff (!arst_n)
      wr && a == ETH_OFS[IX_PAUSE] && !bus_req.be[3] |=> !pause_go_r;
   endproperty
   a_no_pause: assert property (p_no_pause)
      else $error("pause fired without top byte");
   property p_cor;
      @(posedge ref_clk) disable iff (!arst_n)
      rd && bus_req.be[3] && a == ETH_OFS[IX_TOTAL_TX] && !tx_done_inc
         |=> eth_cfg_r[IX_TOTAL_TX] == ZERO32;
   endproperty
   a_cor: assert property (p_cor)
      else $error("counter not cleared on read");
   property p_umap;
      @(posedge ref_clk) disable iff (!arst_n)
      take && umap |=> bus_ack_r && bus_rdata_r == ZERO32
         && eth_cfg_r[IX_TOTAL_TX-1:0] == $past(eth_cfg_r[IX_TOTAL_TX-1:0])
         && eth_cfg_r[NETH-1:IX_PAUSE] == $past(eth_cfg_r[NETH-1:IX_PAUSE]);
   endproperty
   a_umap: assert property (p_umap)
      else $error("unmapped access misbehaved");
   c_ext: cover property (@(posedge ref_clk) ext_r.valid && ext_done);
   c_pause: cover property (@(posedge ref_clk) pause_go_r);
   c_hit: cover property (@(posedge ref_clk) perf_hit_r || hash_hit_r);
   c_irq: cover property (@(posedge ref_clk) card_irq_r);
endmodule // earm_regmap

/* bench/earm_ext_model.sv */
// model of the PHY management, statistics and FIFO units on the ext port
`timescale 1ns/1ps
module earm_ext_model import earm_pkg::*; (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire earm_ext_s ext_r,
   output logic ext_done,
   output logic [31:0] ext_rdata
);
   // ***************************
   // slow, varying responder
   // ***************************
   logic [31:0] mem [int];
   logic [31:0] lf = 32'h1234_5678;
   logic busy = 1'b0, hold = 1'b0;
   int cnt = 0;
   int key;
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ext_done <= 1'b0;
         ext_rdata <= '0;
         busy = 1'b0;
         hold = 1'b0;
      end else begin
         // PHY slots keyed by phy and register number, others by target and address
         key = (ext_r.tgt == TGT_PHY) ? {22'h0, ext_r.phy, ext_r.reg_no}
            : {14'h0, ext_r.tgt, ext_r.addr};
         ext_done <= 1'b0;
         ext_rdata <= ~ext_rdata;
         if (hold) begin
            hold = 1'b0;
         end else if (busy) begin
            cnt--;
            if (cnt == 0) begin
               busy = 1'b0;
               hold = 1'b1;
               ext_done <= 1'b1;
               if (ext_r.write) mem[key] = ext_r.wdata;
               else ext_rdata <= mem.exists(key) ? mem[key] : key;
            end
         end else if (ext_r.valid === 1'b1) begin
            lf = lf ^ (lf << 13);
            lf = lf ^ (lf >> 17);
            lf = lf ^ (lf << 5);
            cnt = 1 + int'(lf[1:0]);
            busy = 1'b1;
         end
      end
   end
endmodule // earm_ext_model

/* bench/ethernet_pci_aux_register_map_bench.sv */
// self-checking bench for the auxiliary register map
`timescale 1ns/1ps
module ethernet_pci_aux_register_map_bench import earm_pkg::*;;
   localparam logic [15:0] XA [4] = '{16'h2194, 16'h228C, 16'h7008, 16'hC010};
   logic ref_clk = 1'b0, arst_n = 1'b0;
   earm_req_s bus_req = '0;
   earm_diag_s diag = '0;
   logic tgt_abort = 1'b0, sa_load = 1'b0, tx_done_inc = 1'b0;
   logic rx_byte_inc = 1'b0, da_valid = 1'b0;
   logic [3:0] card_evt_set = 4'h0, card_present = 4'h0;
   logic [31:0] tgt_diag = '0;
   logic [47:0] sa_load_addr = '0, da = '0;
   logic [10:0] tx_pc = '0, rx_pc = '0;
   logic bus_ack_r, bus_busy_r, card_irq_r, pause_go_r, perf_hit_r;
   logic hash_hit_r, ext_done;
   logic [31:0] bus_rdata_r, ext_rdata, tx_insn_r, rx_insn_r;
   earm_ext_s ext_r;
   logic [PAUSE_W-1:0] pause_time_r;
   logic [NETH-1:0][31:0] eth_cfg_r;
   logic [32:0] exp_q [$];
   logic [32:0] e;
   logic [31:0] seed = 32'h0000_005A;
   int n_mismatch = 0, comparisons = 0, n_pause = 0, cyc = 0;

   earm_regmap earm_regmap_i (.ref_clk, .arst_n, .bus_req, .bus_ack_r,
      .bus_rdata_r, .bus_busy_r, .tgt_abort, .tgt_diag, .diag, .sa_load,
      .sa_load_addr, .card_evt_set, .card_present, .card_irq_r, .ext_r,
      .ext_done, .ext_rdata, .pause_go_r, .pause_time_r, .tx_done_inc,
      .rx_byte_inc, .eth_cfg_r, .da_valid, .da, .perf_hit_r, .hash_hit_r,
      .tx_pc, .tx_insn_r, .rx_pc, .rx_insn_r);
   earm_ext_model earm_ext_model_i (.ref_clk, .arst_n, .ext_r, .ext_done,
      .ext_rdata);

   always #4 ref_clk = ~ref_clk;

   // ***************************
   // helpers
   // ***************************
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic final_report();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] g, input logic [31:0] x);
      comparisons++;
      if (g !== x) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h expected %h", $time, g, x);
      end
   endtask

   task automatic acc(input logic w, input logic [15:0] a,
         input logic [3:0] b, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      bus_req <= '{1'b1, w, seed[3], a, b, d};
      exp_q.push_back({~w, d});
      @(posedge ref_clk);
      bus_req.valid <= 1'b0;
      while (bus_ack_r !== 1'b1 && n < 50) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 50) n_mismatch++;
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      acc(1'b1, a, 4'hF, d);
   endtask

   task automatic rd(input logic [15:0] a, input logic [31:0] d);
      acc(1'b0, a, 4'hF, d);
   endtask

   task automatic filt(input logic [47:0] a, input logic p, input logic h);
      @(posedge ref_clk);
      da_valid <= 1'b1;
      da <= a;
      @(posedge ref_clk);
      da_valid <= 1'b0;
      @(posedge ref_clk);
      cmp({30'h0, perf_hit_r, hash_hit_r}, {30'h0, p, h});
   endtask

   // ***************************
   // monitors and timeout
   // ***************************
   always @(posedge ref_clk) begin
      cyc++;
      if (pause_go_r === 1'b1) n_pause++;
      if (ext_done === 1'b1) begin
         cmp({31'h0, bus_busy_r}, 32'h0000_0001);
      end
      if (bus_ack_r === 1'b1) begin
         cmp({31'h0, bus_busy_r}, '0);
         if (exp_q.size() == 0) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, bus_rdata_r, 0);
         end else begin
            e = exp_q.pop_front();
            if (e[32]) cmp(bus_rdata_r, e[31:0]);
         end
      end
      if (cyc == 5000) begin
         n_mismatch++;
         final_report();
      end
   end

   // ***************************
   // scenarios
   // ***************************
   initial begin
      logic [31:0] d;
      logic [47:0] a48;
      logic [8:0] hx;
      logic [31:0] xd [4];
      repeat (5) @(posedge ref_clk);
      arst_n <= 1'b1;
      d = rnd();
      diag <= {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
      tgt_diag <= rnd();
      sa_load_addr <= {d[15:0], rnd()};
      card_present <= d[23:20];
      {tgt_abort, sa_load} <= 2'b11;
      @(posedge ref_clk);
      {tgt_abort, sa_load} <= 2'b00;
      wr(OFS_TGT, ~tgt_diag);
      rd(OFS_TGT, tgt_diag);
      rd(OFS_MST_A, diag.mst_a);
      rd(OFS_MST_B, diag.mst_b);
      rd(OFS_DMA_PTR, diag.dma_ptr);
      for (int i = 0; i < 4; i++) begin
         wr(OFS_BAC0 + 16'(4 * i), ~diag.bac[i]);
         rd(OFS_BAC0 + 16'(4 * i), diag.bac[i]);
      end
      rd(OFS_SA_LO, sa_load_addr[31:0]);
      rd(OFS_SA_HI, {16'h0000, sa_load_addr[47:32]});
      d = rnd();
      wr(OFS_SA_LO, d);
      rd(OFS_SA_LO, d);
      rd(OFS_CPRES, {28'h0, card_present});
      wr(OFS_CFORCE, 32'h0000_0005);
      rd(OFS_CFORCE, '0);
      wr(OFS_CMASK, 32'h0000_0001);
      @(posedge ref_clk);
      cmp({31'h0, card_irq_r}, 32'h0000_0001);
      rd(OFS_CMASK, 32'h0000_0001);
      wr(OFS_CEV, 32'h0000_0001);
      @(posedge ref_clk);
      cmp({31'h0, card_irq_r}, '0);
      card_evt_set <= 4'h8;
      @(posedge ref_clk);
      card_evt_set <= 4'h0;
      rd(OFS_CEV, 32'h0000_000C);
      for (int i = 0; i < NETH; i++) begin
         if (i != IX_PAUSE) begin
            d = rnd();
            wr(ETH_OFS[i], d);
            cmp(eth_cfg_r[i], d);
            rd(ETH_OFS[i], d);
         end
      end
      d = rnd();
      acc(1'b1, ETH_OFS[IX_PAUSE], 4'h7, d);
      repeat (3) @(posedge ref_clk);
      cmp(32'(n_pause), '0);
      wr(ETH_OFS[IX_PAUSE], d);
      repeat (3) @(posedge ref_clk);
      cmp(32'(n_pause), 32'h0000_0001);
      cmp({16'h0, pause_time_r}, {16'h0, d[15:0]});
      {tx_done_inc, rx_byte_inc} <= 2'b11;
      repeat (3) @(posedge ref_clk);
      {tx_done_inc, rx_byte_inc} <= 2'b00;
      for (int k = IX_TOTAL_TX; k <= IX_RX_BYTES; k++) begin
         acc(1'b0, ETH_OFS[k], 4'h1, 32'h0000_0003);
         rd(ETH_OFS[k], 32'h0000_0003);
         rd(ETH_OFS[k], '0);
      end
      wr(16'h4010, 32'hFFFF_FFFF);
      rd(16'h4010, '0);
      rd(16'h502C, '0);
      for (int i = 0; i < PM_WORDS; i++) wr(OFS_PM_LO + 16'(4 * i), '0);
      for (int i = 0; i < HM_WORDS; i++) wr(OFS_HM_LO + 16'(4 * i), '0);
      d = rnd();
      a48 = {d[15:0], rnd() | 32'h0000_0001};
      for (int w = 0; w < 3; w++) begin
         wr(OFS_PM_LO + 16'(80 + 4 * w),
            {16'h0, a48[16 * w +: 16]});
      end
      hx = a48[8:0] ^ a48[17:9] ^ a48[26:18] ^ a48[35:27] ^ a48[44:36]
         ^ {6'h00, a48[47:45]};
      wr(OFS_HM_LO + 16'(4 * hx[8:4]), 32'h0000_0001 << hx[3:0]);
      filt(a48, 1'b1, 1'b1);
      filt(a48 ^ 48'h0000_0001_0000, 1'b0, 1'b0);
      for (int k = 0; k < 2; k++) begin
         d = rnd();
         wr(OFS_TXP_LO + 16'(4 * k + 8), d);
         wr(OFS_RXP_LO + 16'(4 * k + 12), ~d);
         tx_pc <= 11'(k + 2);
         rx_pc <= 11'(k + 3);
         repeat (2) @(posedge ref_clk);
         cmp(tx_insn_r, d);
         cmp(rx_insn_r, ~d);
      end
      rd(16'h23A4, 32'h0000_00E9);
      for (int k = 0; k < 4; k++) begin
         xd[k] = rnd();
         wr(XA[k], xd[k]);
      end
      for (int k = 0; k < 4; k++) rd(XA[k], xd[k]);
      repeat (2) @(posedge ref_clk);
      final_report();
   end
endmodule // ethernet_pci_aux_register_map_bench
